// >>> design/lin_frame_if.sv
// Frame-level link between the bus commander and the motor node
`timescale 1ns/10ps
`default_nettype none
interface lin_frame_if;
    logic       hdr;
    logic [5:0] hdr_id;
    logic       m_valid;
    logic [7:0] m_data;
    logic       s_req;
    logic       s_valid;
    logic [7:0] s_data;
    modport commander (output hdr, hdr_id, m_valid, m_data, s_req, input s_valid, s_data);
    modport responder (input hdr, hdr_id, m_valid, m_data, s_req, output s_valid, s_data);
endinterface : lin_frame_if
`default_nettype wire

// >>> design/stepper_readback_commander.sv
// Bus commander end: AHB-Lite register front end driving readback frames
`timescale 1ns/10ps
`default_nettype none
`include "stepper_readback_params.svh"
module stepper_readback_commander
    import stepper_readback_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic      [31:0] HRDATA,
    output logic             IRQ,
    lin_frame_if.commander   LINK
);

    cmd_state_type state;
    logic [17:0]   ctrl;
    logic          start;
    logic          wr_pend;
    logic [7:0]    wr_addr;
    logic          irq_status;
    logic          irq_enable;
    logic          done_evt;
    logic [5:0]    frame_id;
    logic          to_tx;
    logic          second;
    logic          waiting;
    logic [3:0]    cnt;
    logic [3:0]    rx_len;
    logic [3:0]    rx_base;
    logic [63:0]   tx_frame;
    logic [7:0]    rx [0:15];
    logic          rd_req;
    logic [15:0]   pos_raw;
    logic [15:0]   pos_masked;
    logic [31:0]   rd_word;
    op_type        op;

    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign IRQ       = irq_status & irq_enable;
    assign op        = op_type'(ctrl[1:0]);
    assign rd_req    = HSEL && HREADY && HTRANS[1] && !HWRITE;

    // Reported position with meaningless low bits forced to zero
    assign pos_raw    = (op == OP_FULL) ? {rx[9], rx[10]} : {rx[1], rx[2]};
    assign pos_masked = pos_raw & (16'hFFFF << (2'h3 - ctrl[17:16]));

    // AHB address phase capture
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= HSEL && HREADY && HTRANS[1] && HWRITE;
            wr_addr <= HADDR[7:0];
        end
    end

    // Read data mux, registered in the address phase
    always_comb begin
        if (HADDR[7:0] == `REG_CTRL) begin
            rd_word = {13'h0000, ctrl, 1'b0};
        end else if (HADDR[7:0] == `REG_STATUS) begin
            rd_word = {31'h00000000, (state != CMD_IDLE) || start};
        end else if (HADDR[7:0] == `REG_POSITION) begin
            rd_word = {16'h0000, pos_masked};
        end else if (HADDR[7:0] == `REG_RX0) begin
            rd_word = {rx[0], rx[1], rx[2], rx[3]};
        end else if (HADDR[7:0] == `REG_RX1) begin
            rd_word = {rx[4], rx[5], rx[6], rx[7]};
        end else if (HADDR[7:0] == `REG_RX2) begin
            rd_word = {rx[8], rx[9], rx[10], rx[11]};
        end else if (HADDR[7:0] == `REG_RX3) begin
            rd_word = {rx[12], rx[13], rx[14], rx[15]};
        end else if (HADDR[7:0] == `REG_IRQ_STATUS) begin
            rd_word = {31'h00000000, irq_status};
        end else if (HADDR[7:0] == `REG_IRQ_ENABLE) begin
            rd_word = {31'h00000000, irq_enable};
        end else begin
            rd_word = 32'h00000000;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            HRDATA <= 32'h00000000;
        end else if (rd_req) begin
            HRDATA <= rd_word;
        end
    end

    // Register writes; a start while busy is ignored
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ctrl       <= 18'h00000;
            start      <= 1'b0;
            irq_enable <= 1'b0;
        end else begin
            start <= 1'b0;
            if (wr_pend && wr_addr == `REG_CTRL && state == CMD_IDLE && !start) begin
                ctrl  <= HWDATA[`CTRL_MSB:`CTRL_LSB];
                start <= HWDATA[`CTRL_GO];
            end else if (wr_pend && wr_addr == `REG_IRQ_ENABLE) begin
                irq_enable <= HWDATA[0];
            end
        end
    end

    // Sticky completion event, write-one clear, set wins
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            irq_status <= 1'b0;
        end else if (done_evt) begin
            irq_status <= 1'b1;
        end else if (wr_pend && wr_addr == `REG_IRQ_CLEAR && HWDATA[0]) begin
            irq_status <= 1'b0;
        end
    end

    // Frame sequencer
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state        <= CMD_IDLE;
            frame_id     <= 6'h00;
            to_tx        <= 1'b0;
            second       <= 1'b0;
            waiting      <= 1'b0;
            cnt          <= 4'h0;
            rx_len       <= 4'h0;
            rx_base      <= 4'h0;
            tx_frame     <= 64'h0000000000000000;
            done_evt     <= 1'b0;
            LINK.hdr     <= 1'b0;
            LINK.hdr_id  <= 6'h00;
            LINK.m_valid <= 1'b0;
            LINK.m_data  <= 8'h00;
            LINK.s_req   <= 1'b0;
        end else begin
            LINK.hdr     <= 1'b0;
            LINK.m_valid <= 1'b0;
            LINK.s_req   <= 1'b0;
            done_evt     <= 1'b0;
            case (state)
                CMD_IDLE: begin
                    if (start) begin
                        rx_base <= 4'h0;
                        second  <= (op == OP_FULL);
                        state   <= CMD_HDR;
                        if (op == OP_POS_DIRECT) begin
                            frame_id <= ctrl[15:10];
                            to_tx    <= 1'b0;
                            rx_len   <= 4'h4;
                        end else begin
                            frame_id <= `ID_PREPARE;
                            to_tx    <= 1'b1;
                            rx_len   <= 4'h8;
                            tx_frame <= {1'b1, (op == OP_POS_INDIRECT) ? `CMD_READ_POSITION
                                                                       : `CMD_READ_COMPLETE,
                                         ctrl[2], ctrl[9:3], {6{`FILL_BYTE}}};
                        end
                    end
                end
                CMD_HDR: begin
                    LINK.hdr    <= 1'b1;
                    LINK.hdr_id <= frame_id;
                    cnt         <= 4'h0;
                    waiting     <= 1'b0;
                    state       <= to_tx ? CMD_TX : CMD_RX;
                end
                CMD_TX: begin
                    LINK.m_valid <= 1'b1;
                    LINK.m_data  <= tx_frame[63:56];
                    tx_frame     <= {tx_frame[55:0], `FILL_BYTE};
                    cnt          <= cnt + 4'h1;
                    if (cnt == 4'h7) begin
                        frame_id <= `ID_REPLY;
                        to_tx    <= 1'b0;
                        state    <= CMD_HDR;
                    end
                end
                CMD_RX: begin
                    if (!waiting) begin
                        LINK.s_req <= 1'b1;
                        waiting    <= 1'b1;
                    end else if (LINK.s_valid) begin
                        rx[rx_base + cnt] <= LINK.s_data;
                        waiting           <= 1'b0;
                        cnt               <= cnt + 4'h1;
                        if (cnt == rx_len - 4'h1) begin
                            if (second) begin
                                second   <= 1'b0;
                                rx_base  <= 4'h8;
                                frame_id <= `ID_REPLY;
                                state    <= CMD_HDR;
                            end else begin
                                done_evt <= 1'b1;
                                state    <= CMD_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    state <= CMD_IDLE;
                end
            endcase
        end
    end

endmodule : stepper_readback_commander
`default_nettype wire

// >>> design/stepper_readback_params.svh
// Constants shared by both ends of the stepper readback link
`ifndef STEPPER_READBACK_PARAMS_SVH
`define STEPPER_READBACK_PARAMS_SVH
// Frame identifiers and command codes
`define ID_PREPARE        6'h3C
`define ID_REPLY          6'h3D
`define CMD_READ_POSITION 7'h00
`define CMD_READ_COMPLETE 7'h01
`define FILL_BYTE         8'hFF
// Flag vector bit positions
`define FLAG_HOT_WARN     0
`define FLAG_HOT_STOP     1
`define FLAG_UV           2
`define FLAG_ELDEF        3
`define FLAG_LOST_STEPS   4
`define FLAG_CPFAIL       5
`define FLAG_OVCX         6
`define FLAG_OVCY         7
`define FLAG_SUPPLY       8
`define FLAGS_RESET       9'h110
`define FLAGS_ALL         9'h1FF
`define FLAGS_NO_THERMAL  9'h1FC
// Controller register byte offsets
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_POSITION      8'h08
`define REG_RX0           8'h0C
`define REG_RX1           8'h10
`define REG_RX2           8'h14
`define REG_RX3           8'h18
`define REG_IRQ_STATUS    8'h1C
`define REG_IRQ_CLEAR     8'h20
`define REG_IRQ_ENABLE    8'h24
// Control register fields
`define CTRL_GO           0
`define CTRL_LSB          1
`define CTRL_MSB          18
`endif

// >>> design/stepper_readback_pkg.sv
// Types shared by both ends of the stepper readback link
package stepper_readback_pkg;
    typedef enum logic [2:0] {
        RSP_IDLE = 3'b001,
        RSP_PREP = 3'b010,
        RSP_SEND = 3'b100
    } resp_state_type;
    typedef enum logic [3:0] {
        PEND_NONE  = 4'b0001,
        PEND_POS   = 4'b0010,
        PEND_FULL1 = 4'b0100,
        PEND_FULL2 = 4'b1000
    } pend_type;
    typedef enum logic [3:0] {
        CMD_IDLE = 4'b0001,
        CMD_HDR  = 4'b0010,
        CMD_TX   = 4'b0100,
        CMD_RX   = 4'b1000
    } cmd_state_type;
    typedef enum logic [1:0] {
        OP_POS_DIRECT   = 2'h0,
        OP_POS_INDIRECT = 2'h1,
        OP_FULL         = 2'h2,
        OP_FULL_FIRST   = 2'h3
    } op_type;
endpackage : stepper_readback_pkg

// >>> design/stepper_readback_responder.sv
// Motor node end: position and status readback over the frame link
// Contract
// - Broadcast bit 0 executes regardless of address.
// - Dynamic identifiers serve generic frames; others declared.
// - Position is signed 16-bit, high byte first.
// - Master zeroes position LSBs below resolution.
// - Position read never clears any flag.
// - Direct answer: switch/address, position, status byte.
// - Master uses one direct identifier per motor.
// - Indirect: prepare 0x00 frame, 0x3D reply, fill.
// - Complete status read clears latched flags, thermal ones per below.
// - Complete status: prepare then two 0x3D replies.
// - First reply: settings, status, motion, errors, fill.
// - Second reply: address, actual, target, secure positions.
// - Second reply may be omitted; node tolerates it.
// - Temperature field: normal, low, high, shutdown.
// - Motion field: stop, inner phases, outer phases.
// - Thermal flags clear only while temperature normal.
// - Supply-reset flag is one after power-up.
`timescale 1ns/10ps
`default_nettype none
`include "stepper_readback_params.svh"
module stepper_readback_responder
    import stepper_readback_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    lin_frame_if.responder   LINK,
    input  wire logic [6:0]  NODE_ADDRESS,
    input  wire logic [5:0]  POSITION_ID,
    input  wire logic [15:0] ACTUAL_POSITION,
    input  wire logic [15:0] TARGET_POSITION,
    input  wire logic [10:0] SECURE_POSITION,
    input  wire logic [2:0]  MOTION_STATE,
    input  wire logic [1:0]  TEMPERATURE_INFO,
    input  wire logic        EXTERNAL_SWITCH_STATE,
    input  wire logic [3:0]  RUN_CURRENT_INDEX,
    input  wire logic [3:0]  HOLD_CURRENT_INDEX,
    input  wire logic [3:0]  MAX_VELOCITY_INDEX,
    input  wire logic [3:0]  MIN_VELOCITY_INDEX,
    input  wire logic        ACCELERATION_SHAPE,
    input  wire logic [1:0]  MICROSTEP_RESOLUTION,
    input  wire logic        SHAFT_DIRECTION,
    input  wire logic [3:0]  ACCELERATION_INDEX,
    input  wire logic [7:0]  LIN_ERROR_STATUS,
    input  wire logic [8:0]  FLAG_EVENTS,
    output logic      [8:0]  FLAGS
);

    resp_state_type state;
    pend_type       pend;
    logic [1:0]     prep_cnt;
    logic [7:0]     cmd_byte;
    logic [63:0]    resp_frame;
    logic [7:0]     status_byte;
    logic [7:0]     motion_byte;
    logic [63:0]    pos_frame;
    logic [63:0]    full1_frame;
    logic [63:0]    full2_frame;
    logic           hit_prep;
    logic           hit_pos;
    logic           hit_reply;
    logic           load_full;
    logic           for_us;
    logic [8:0]     clear_mask;

    // Header classification; the prepare identifier outranks the direct one, which outranks the reply one
    assign hit_prep  = LINK.hdr && (LINK.hdr_id == `ID_PREPARE);
    assign hit_pos   = LINK.hdr && !hit_prep && (LINK.hdr_id == POSITION_ID);
    assign hit_reply = LINK.hdr && !hit_prep && !hit_pos
                       && (LINK.hdr_id == `ID_REPLY) && (pend != PEND_NONE);
    assign load_full = hit_reply && (pend == PEND_FULL1);

    // Address byte: broadcast select low accepts any address
    assign for_us = !LINK.m_data[7] || (LINK.m_data[6:0] == NODE_ADDRESS);

    // Short status byte shared by the position reply and the first complete status reply
    assign status_byte = {FLAGS[`FLAG_SUPPLY], FLAGS[`FLAG_LOST_STEPS], FLAGS[`FLAG_ELDEF],
                          FLAGS[`FLAG_UV], FLAGS[`FLAG_HOT_STOP], FLAGS[`FLAG_HOT_WARN],
                          TEMPERATURE_INFO};

    // Motion phase, switch, coil overcurrent and charge pump byte
    assign motion_byte = {MOTION_STATE, EXTERNAL_SWITCH_STATE, FLAGS[`FLAG_OVCX],
                          FLAGS[`FLAG_OVCY], 1'b1, FLAGS[`FLAG_CPFAIL]};

    // Position reply: four payload bytes then fill
    assign pos_frame = {EXTERNAL_SWITCH_STATE, NODE_ADDRESS,
                        ACTUAL_POSITION[15:8], ACTUAL_POSITION[7:0],
                        status_byte, {4{`FILL_BYTE}}};

    // First complete status reply
    assign full1_frame = {1'b1, NODE_ADDRESS,
                          RUN_CURRENT_INDEX, HOLD_CURRENT_INDEX,
                          MAX_VELOCITY_INDEX, MIN_VELOCITY_INDEX,
                          ACCELERATION_SHAPE, MICROSTEP_RESOLUTION, SHAFT_DIRECTION,
                          ACCELERATION_INDEX,
                          status_byte, motion_byte, LIN_ERROR_STATUS,
                          `FILL_BYTE};

    // Second complete status reply
    assign full2_frame = {1'b1, NODE_ADDRESS,
                          ACTUAL_POSITION, TARGET_POSITION,
                          SECURE_POSITION[7:0], 5'h1F, SECURE_POSITION[10:8],
                          `FILL_BYTE};

    // Thermal flags stay latched while the temperature is out of range
    assign clear_mask = (TEMPERATURE_INFO == 2'h0) ? `FLAGS_ALL
                                                   : `FLAGS_NO_THERMAL;

    // Latched flags: events set, complete status read clears, set wins
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            FLAGS <= `FLAGS_RESET;
        end else if (load_full) begin
            // Reply already captured this edge, so old values go out first
            FLAGS <= (FLAGS & ~clear_mask) | FLAG_EVENTS;
        end else begin
            FLAGS <= FLAGS | FLAG_EVENTS;
        end
    end

    // Prepare frame decode and pending command
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pend     <= PEND_NONE;
            prep_cnt <= 2'h0;
            cmd_byte <= 8'h00;
        end else if (hit_prep) begin
            // A fresh prepare frame drops any unread second reply
            pend     <= PEND_NONE;
            prep_cnt <= 2'h0;
        end else if (hit_reply) begin
            pend <= (pend == PEND_FULL1) ? PEND_FULL2 : PEND_NONE;
        end else if (state == RSP_PREP && LINK.m_valid && prep_cnt != 2'h2) begin
            prep_cnt <= prep_cnt + 2'h1;
            if (prep_cnt == 2'h0) begin
                cmd_byte <= LINK.m_data;
            end else if (cmd_byte[7] && for_us) begin
                if (cmd_byte[6:0] == `CMD_READ_POSITION) begin
                    pend <= PEND_POS;
                end else if (cmd_byte[6:0] == `CMD_READ_COMPLETE) begin
                    pend <= PEND_FULL1;
                end else begin
                    pend <= PEND_NONE;
                end
            end else begin
                // Addressed to another node: its reply is not ours
                pend <= PEND_NONE;
            end
        end
    end

    // Frame state and reply byte stream
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state        <= RSP_IDLE;
            resp_frame   <= {8{`FILL_BYTE}};
            LINK.s_valid <= 1'b0;
            LINK.s_data  <= 8'h00;
        end else begin
            LINK.s_valid <= 1'b0;
            if (hit_prep) begin
                state <= RSP_PREP;
            end else if (hit_pos) begin
                // Whole reply sampled at once keeps position bytes coherent
                resp_frame <= pos_frame;
                state      <= RSP_SEND;
            end else if (hit_reply) begin
                if (pend == PEND_POS) begin
                    resp_frame <= pos_frame;
                end else if (pend == PEND_FULL1) begin
                    resp_frame <= full1_frame;
                end else begin
                    resp_frame <= full2_frame;
                end
                state <= RSP_SEND;
            end else if (LINK.hdr) begin
                state <= RSP_IDLE;
            end else begin
                case (state)
                    RSP_SEND: begin
                        if (LINK.s_req) begin
                            LINK.s_valid <= 1'b1;
                            LINK.s_data  <= resp_frame[63:56];
                            resp_frame   <= {resp_frame[55:0], `FILL_BYTE};
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

endmodule : stepper_readback_responder
`default_nettype wire

// >>> verif/stepper_readback_asserts.sv
// Checker on the frame link between the commander and responder ends
`timescale 1ns/10ps
`default_nettype none
`include "stepper_readback_params.svh"
module stepper_readback_asserts (
    input wire logic       CLK_SYS,
    input wire logic       RST,
    input wire logic       hdr,
    input wire logic [5:0] hdr_id,
    input wire logic       m_valid,
    input wire logic [7:0] m_data,
    input wire logic       s_req,
    input wire logic       s_valid,
    input wire logic [8:0] FLAGS
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);
    // Prepare header and its body of command bytes
    sequence prep_start;
        hdr && hdr_id == `ID_PREPARE;
    endsequence
    sequence prep_body;
        m_valid [*8];
    endsequence
    chk_prep_body: assert property (prep_start |=> prep_body)
        else $error("prepare frame lacks its eight bytes");
    chk_cmd_msb: assert property (prep_start |=> m_data[7])
        else $error("command byte sent with bit 7 low");
    chk_reply_follows: assert property (prep_start |-> ##9 (hdr && hdr_id == `ID_REPLY))
        else $error("reply header does not follow prepare frame");
    chk_reply_lag: assert property (s_req |=> s_valid)
        else $error("reply byte not one cycle after request");
    chk_reply_cause: assert property (s_valid |-> $past(s_req))
        else $error("reply byte without a request");
    chk_hdr_quiet: assert property (hdr |-> !m_valid && !s_valid)
        else $error("data moving during a header");
    chk_flags_reset: assert property ($fell(RST) |-> FLAGS == `FLAGS_RESET)
        else $error("flags wrong after reset");
    // A flag may only drop just after a reply header was taken
    chk_clear_cause: assert property (|($past(FLAGS) & ~FLAGS) |->
        $past(hdr) && $past(hdr_id) == `ID_REPLY)
        else $error("flag cleared outside a status reply");
endmodule : stepper_readback_asserts
`default_nettype wire

// >>> verif/tb_stepper_status_readback.sv
// Testbench: AHB-Lite driven readback of position and status over the link
`timescale 1ns/10ps
`default_nettype none
module tb_stepper_status_readback;
    import stepper_readback_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hreadyout;
    logic        irq;
    logic [1:0]  temp = 2'b01;
    logic [8:0]  events = 9'h0;
    logic [8:0]  flags;
    logic [3:0]  run_i = 4'h3, hold_i = 4'hA, vel_hi = 4'hC, vel_lo = 4'h5, acc = 4'h6;
    logic [15:0] act_pos = 16'h8ABC;
    logic [7:0]  lin_err = 8'h5A;
    logic [2:0]  motion = 3'b101;
    logic [1:0]  step_res = 2'b10;
    logic        external_switch_state = 1'b1, shape = 1'b1, shaft = 1'b0;
    logic        hresp;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cycles = 0;
    lin_frame_if link();
    stepper_readback_commander u_stepper_readback_commander (
        .CLK_SYS(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .IRQ(irq), .LINK(link));
    stepper_readback_responder u_stepper_readback_responder (
        .CLK_SYS(clk), .RST(rst), .LINK(link), .NODE_ADDRESS(7'h25),
        .POSITION_ID(6'h12), .ACTUAL_POSITION(act_pos), .TARGET_POSITION(16'h1234),
        .SECURE_POSITION(11'h5E7), .MOTION_STATE(motion), .TEMPERATURE_INFO(temp),
        .EXTERNAL_SWITCH_STATE(external_switch_state), .RUN_CURRENT_INDEX(run_i),
        .HOLD_CURRENT_INDEX(hold_i), .MAX_VELOCITY_INDEX(vel_hi), .MIN_VELOCITY_INDEX(vel_lo),
        .ACCELERATION_SHAPE(shape), .MICROSTEP_RESOLUTION(step_res), .SHAFT_DIRECTION(shaft),
        .ACCELERATION_INDEX(acc), .LIN_ERROR_STATUS(lin_err), .FLAG_EVENTS(events),
        .FLAGS(flags));
    stepper_readback_asserts u_stepper_readback_asserts (
        .CLK_SYS(clk), .RST(rst), .hdr(link.hdr), .hdr_id(link.hdr_id),
        .m_valid(link.m_valid), .m_data(link.m_data), .s_req(link.s_req),
        .s_valid(link.s_valid), .FLAGS(flags));
    // Clock and hang guard
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    // Live position flips after each reply byte; every reply has an even byte count,
    // so a reply sampled whole at its start still carries the original value
    always @(posedge clk) begin
        if (link.s_valid) begin
            act_pos <= ~act_pos;
        end
    end
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask : check
    // One single word transfer; entered right after a rising edge
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic rdck(input logic [31:0] a, input logic [31:0] exp, input string name);
        ahb(1'b0, a, 32'h0);
        check(name, exp, rd);
        check("hresp okay", 32'h0, {31'h0, hresp});
    endtask : rdck
    function automatic logic [31:0] ctl(input logic [1:0] op, input logic sel,
                                        input logic [6:0] a, input logic [1:0] res);
        return {13'h0, res, 6'h12, a, sel, op, 1'b1};
    endfunction : ctl
    // Start an operation, wait till idle, then check and clear the done interrupt
    task automatic run(input logic [31:0] ctrl, input logic en);
        int i;
        ahb(1'b1, 32'h24, {31'h0, en});
        ahb(1'b1, 32'h0, ctrl);
        ahb(1'b0, 32'h4, 32'h0);
        for (i = 0; i < 40 && rd[0] !== 1'b0; i++) ahb(1'b0, 32'h4, 32'h0);
        check("busy done", 32'h0, {31'h0, rd[0]});
        rdck(32'h1C, 32'h1, "irq status");
        #1 check("irq level", {31'h0, en}, {31'h0, irq});
        @(posedge clk);
        ahb(1'b1, 32'h20, 32'h1);
        #1 check("irq cleared", 32'h0, {31'h0, irq});
        @(posedge clk);
    endtask : run
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("flags reset", 32'h110, {23'h0, flags});
        rdck(32'h0, 32'h0, "ctrl reset");
        rdck(32'h40, 32'h0, "unmapped");
        // Direct position read at full resolution
        run(ctl(2'h0, 1'b1, 7'h25, 2'h3), 1'b1);
        ahb(1'b0, 32'h8, 32'h0);
        check("position", 32'h8ABC, {16'h0, rd[15:0]});
        rdck(32'hC, 32'hA58ABCC1, "direct reply");
        check("flags kept", 32'h110, {23'h0, flags});
        // Indirect read, broadcast to a foreign address, interrupt masked
        run(ctl(2'h1, 1'b0, 7'h11, 2'h0), 1'b0);
        ahb(1'b0, 32'h8, 32'h0);
        check("coarse position", 32'h8AB8, {16'h0, rd[15:0]});
        rdck(32'hC, 32'hA58ABCC1, "indirect reply");
        rdck(32'h10, 32'hFFFFFFFF, "indirect fill");
        check("flags kept", 32'h110, {23'h0, flags});
        // Full status with every flag raised, temperature not normal
        events <= 9'h1FF;
        @(posedge clk);
        events <= 9'h0;
        run(ctl(2'h2, 1'b1, 7'h25, 2'h3), 1'b1);
        rdck(32'hC, 32'hA53AC5C6, "full part one a");
        rdck(32'h10, 32'hFDBF5AFF, "full part one b");
        rdck(32'h14, 32'hA58ABC12, "full part two a");
        rdck(32'h18, 32'h34E7FDFF, "full part two b");
        check("flags cleared", 32'h003, {23'h0, flags});
        // First part only, temperature normal: thermal flags seen once, then gone
        temp <= 2'b00;
        run(ctl(2'h3, 1'b1, 7'h25, 2'h3), 1'b1);
        rdck(32'h10, 32'h0CB25AFF, "thermal seen");
        check("thermal cleared", 32'h0, {23'h0, flags});
        external_switch_state <= 1'b0;
        motion <= 3'b011;
        shaft <= 1'b1;
        run(ctl(2'h3, 1'b1, 7'h25, 2'h3), 1'b1);
        rdck(32'hC, 32'hA53AC5D6, "shaft reversed");
        rdck(32'h10, 32'h00625AFF, "thermal gone");
        end_sim();
    end
endmodule : tb_stepper_status_readback
`default_nettype wire
